/* src/sleep_doze_pkg.sv */
// constants, field layouts and carrier types for the wake-cause, persistent store and doze block
// assumes a 125 MHz sys_clk and an apb master with 32-bit data
// Contract
// - 16-bit register of sticky wake-cause flags
// - power-on flag needs active detector, any mode
// - two read-write 16-bit persistent store registers
// - only power-on outside deep sleep clears stores
// - doze slows cpu only, peripherals full rate
// - cpu and peripheral clocks stay in step
// - bit 11 enables doze reduction
// - bits 14:12 pick ratio, reset 1:1
// - return-on-interrupt clears doze enable on interrupt
package sleep_doze_pkg;
    // byte addresses of the registers on apb
    localparam logic [11:0] addr_wake_cause = 12'h000;
    localparam logic [11:0] addr_store_0 = 12'h004;
    localparam logic [11:0] addr_store_1 = 12'h008;
    localparam logic [11:0] addr_clock_div = 12'h00c;
    // wake-cause field positions
    localparam int bit_power_on = 0;
    localparam int bit_master_clear = 2;
    localparam int bit_calendar = 3;
    localparam int bit_watchdog = 4;
    localparam int bit_fault = 7;
    localparam logic [15:0] wake_cause_mask = 16'h009d;
    // clock divider field positions and reset value
    localparam int bit_doze_enable = 11;
    localparam int bit_ratio_lo = 12;
    localparam int bit_return_on_int = 15;
    localparam logic [15:0] clock_div_mask = 16'hf800;
    localparam logic [15:0] clock_div_reset = 16'h0000;
    localparam logic [2:0] ratio_reset = 3'h0;
    // power-on reset value chosen for the persistent stores
    localparam logic [15:0] store_reset = 16'h0000;
    // wake events from the always-on domain, one-cycle pulses
    typedef struct packed {
        logic fault;
        logic watchdog;
        logic calendar;
        logic master_clear;
    } wake_events_t;
    // doze settings as applied to the divider
    typedef struct packed {
        logic enable;
        logic [2:0] ratio;
    } doze_cfg_t;
endpackage

/* src/wake_flag_bit.sv */
// one sticky flag: set by hardware, written by software, set wins
// assumes set and write arrive synchronous to sys_clk
module wake_flag_bit (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic set,
    input wire logic wr,
    input wire logic wdata,
    output logic flag
);
    // an event in the same cycle as a software write is not lost
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else if (ce) begin
            if (set) begin
                flag <= 1'b1;
            end else if (wr) begin
                flag <= wdata;
            end
        end
    end
endmodule

/* src/cpu_clock_gate.sv */
// cpu clock-enable divider for doze; peripherals stay on every enabled sys_clk edge
// assumes cfg is a registered setting from the same clock domain
module cpu_clock_gate
    import sleep_doze_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input sleep_doze_pkg::doze_cfg_t cfg,
    output logic cpu_tick,
    output logic [2:0] active_ratio
);
    logic [6:0] count; // position inside current cpu period
    logic [6:0] limit; // last count of the active period
    doze_cfg_t live; // setting in force for this period
    always_comb begin
        limit = live.enable ? 7'((8'h1 << live.ratio) - 8'h1) : 7'h0;
    end
    // counter and tick share sys_clk so the domains stay aligned
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count <= 7'h0;
            cpu_tick <= 1'b0;
            live <= '0;
        end else if (ce) begin
            if (count >= limit) begin
                count <= 7'h0;
                cpu_tick <= 1'b1;
                live <= cfg; // taken only at a period end, never mid-pulse
            end else begin
                count <= 7'(count + 7'h1);
                cpu_tick <= 1'b0;
            end
        end
    end
    // ratio in force moves at the same edge as the tick that opens its period,
    // so an observer never sees the ratio change between two cpu ticks
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            active_ratio <= ratio_reset;
        end else if (ce) begin
            if (count >= limit) begin
                active_ratio <= cfg.enable ? cfg.ratio : 3'h0;
            end
        end
    end
endmodule

/* src/sleep_doze_top.sv */
// apb register block: wake-cause flags, two persistent stores, doze control
// assumes wake events are synchronous pulses; power_on_event and in_deep_sleep
// come from pins outside this clock and are synchronised here
//
// Local design decisions: the address map and register access over APB.
module sleep_doze_top
    import sleep_doze_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input sleep_doze_pkg::wake_events_t wake_events,
    input wire logic in_deep_sleep,
    input wire logic power_on_detect_active,
    input wire logic power_on_event,
    input wire logic interrupt_event,
    output logic cpu_tick,
    output logic periph_tick,
    output logic [2:0] active_ratio
);
    logic [2:0] por_sync; // three-stage capture of the power-on pin
    logic [2:0] sleep_sync; // three-stage capture of deep-sleep state
    logic por_level; // agreed power-on level
    logic sleep_level; // agreed deep-sleep level
    logic por_prev; // for edge detection on agreed level
    logic por_rise; // one-cycle power-on event
    logic access; // apb access phase
    logic wr_en; // write strobe
    logic [15:0] wake_cause_flags;
    logic [15:0] persistent_store_0;
    logic [15:0] persistent_store_1;
    logic [15:0] clock_divider_register;
    logic [3:0] flag_set; // per-flag hardware set
    logic [15:0] wake_q; // flag outputs before packing
    logic wake_wr;
    logic [31:0] next_prdata;
    logic next_err;
    doze_cfg_t cfg;

    assign access = psel && penable;
    assign wr_en = access && pwrite;
    assign wake_wr = wr_en && (paddr == addr_wake_cause);

    // pin capture: first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            por_sync <= 3'h0;
            sleep_sync <= 3'h0;
        end else if (ce) begin
            por_sync <= {por_sync[1:0], power_on_event};
            sleep_sync <= {sleep_sync[1:0], in_deep_sleep};
        end
    end

    // a level counts only once stages two and three agree
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            por_level <= 1'b0;
            sleep_level <= 1'b0;
            por_prev <= 1'b0;
        end else if (ce) begin
            if (por_sync[1] == por_sync[2]) begin
                por_level <= por_sync[2];
            end
            if (sleep_sync[1] == sleep_sync[2]) begin
                sleep_level <= sleep_sync[2];
            end
            por_prev <= por_level;
        end
    end
    assign por_rise = por_level && !por_prev;

    // only events seen during deep sleep mark a cause; power-on is the exception
    always_comb begin
        flag_set[0] = por_rise && power_on_detect_active;
        flag_set[1] = wake_events.master_clear && sleep_level;
        flag_set[2] = wake_events.calendar && sleep_level;
        flag_set[3] = wake_events.watchdog && sleep_level;
    end

    // wake-cause bits; fault is separate below
    localparam int flag_pos [4] = '{bit_power_on, bit_master_clear, bit_calendar, bit_watchdog};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flag
            wake_flag_bit u_flag (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .ce(ce),
                .set(flag_set[gi]),
                .wr(wake_wr),
                .wdata(pwdata[flag_pos[gi]]),
                .flag(wake_q[flag_pos[gi]])
            );
        end
    endgenerate

    // fault flag stays clear unless a fault hits during deep sleep or software writes a one to it
    wake_flag_bit u_fault (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .set(wake_events.fault && sleep_level),
        .wr(wake_wr),
        .wdata(pwdata[bit_fault]),
        .flag(wake_q[bit_fault])
    );
    assign wake_q[1] = 1'b0;
    assign wake_q[6:5] = 2'h0;
    assign wake_q[15:8] = 8'h00;
    assign wake_cause_flags = wake_q & wake_cause_mask;

    // persistent stores: no async reset so rstn leaves them alone; only a
    // power-on outside deep sleep clears them. plain rstn cannot reach them.
    always_ff @(posedge sys_clk) begin
        if (ce) begin
            if (por_rise && !sleep_level) begin
                persistent_store_0 <= store_reset;
                persistent_store_1 <= store_reset;
            end else if (wr_en) begin
                if (paddr == addr_store_0) begin
                    persistent_store_0 <= pwdata[15:0];
                end
                if (paddr == addr_store_1) begin
                    persistent_store_1 <= pwdata[15:0];
                end
            end
        end
    end

    // clock divider: interrupt clearing of enable wins over a software write
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clock_divider_register <= clock_div_reset;
        end else if (ce) begin
            if (wr_en && paddr == addr_clock_div) begin
                clock_divider_register <= pwdata[15:0] & clock_div_mask;
            end
            if (interrupt_event && clock_divider_register[bit_return_on_int]
                    && clock_divider_register[bit_doze_enable]) begin
                clock_divider_register[bit_doze_enable] <= 1'b0;
            end
        end
    end

    assign cfg.enable = clock_divider_register[bit_doze_enable];
    assign cfg.ratio = clock_divider_register[bit_ratio_lo +: 3];

    // divided cpu enable; peripherals keep full rate
    cpu_clock_gate u_gate (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .cfg(cfg),
        .cpu_tick(cpu_tick),
        .active_ratio(active_ratio)
    );

    // peripheral tick on every enabled edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            periph_tick <= 1'b0;
        end else begin
            periph_tick <= ce;
        end
    end

    // read mux; unmapped addresses read zero with pslverr
    always_comb begin
        next_prdata = 32'h0;
        next_err = 1'b0;
        if (paddr == addr_wake_cause) begin
            next_prdata = {16'h0, wake_cause_flags};
        end else if (paddr == addr_store_0) begin
            next_prdata = {16'h0, persistent_store_0};
        end else if (paddr == addr_store_1) begin
            next_prdata = {16'h0, persistent_store_1};
        end else if (paddr == addr_clock_div) begin
            next_prdata = {16'h0, clock_divider_register};
        end else begin
            next_err = 1'b1;
        end
    end

    // zero-wait answer registered at the setup edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && next_err;
            if (psel && !penable && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end
endmodule

/* sim/sleep_doze_asserts.sv */
// port checker for the wake-cause, persistent store and doze block
// assumes one sys_clk domain with rstn as its asynchronous reset
module sleep_doze_asserts (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cpu_tick,
    input wire logic periph_tick,
    input wire logic [2:0] active_ratio
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // sampled rstn in the antecedents keeps the release edge, where the
    // flops still sit in reset, from starting an attempt
    // every setup cycle is answered in the access cycle that follows
    setup_ready_a: assert property (rstn && ce && psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    unmapped_err_a: assert property (
        pready && paddr > 12'h00c |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    upper_zero_a: assert property (
        pready && paddr <= 12'h00c |-> !pslverr && prdata[31:16] == 16'h0)
        else $error("mapped access refused or wide");
    // peripherals keep full rate whatever the cpu does
    periph_rate_a: assert property (rstn && ce |=> periph_tick)
        else $error("peripheral tick missing");
    full_rate_a: assert property (
        rstn && ce && active_ratio == 3'h0 |=> cpu_tick || active_ratio != 3'h0)
        else $error("cpu slowed at 1:1");
    half_rate_a: assert property (
        rstn && ce && cpu_tick && active_ratio == 3'h1 |=> !cpu_tick || active_ratio != 3'h1)
        else $error("cpu tick too early at 1:2");
    ratio_step_a: assert property ($changed(active_ratio) |-> cpu_tick)
        else $error("ratio changed between cpu ticks");
    unmapped_c: cover property (pready && pslverr);
    slowest_c: cover property (active_ratio == 3'h7 && cpu_tick);
    half_c: cover property (cpu_tick && active_ratio == 3'h1);
endmodule
bind sleep_doze_top sleep_doze_asserts chk_i (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_tick(cpu_tick), .periph_tick(periph_tick),
    .active_ratio(active_ratio));

/* sim/wake_source.sv */
// model of the always-on side: wake events, supply reset pin, interrupts
// assumes the caller enters its tasks just after a rising edge
module wake_source
    import sleep_doze_pkg::*;
(
    input wire logic sys_clk,
    output sleep_doze_pkg::wake_events_t wake_events,
    output logic in_deep_sleep,
    output logic power_on_detect_active,
    output logic power_on_event,
    output logic interrupt_event
);
    timeunit 1ns;
    timeprecision 1ps;
    // quiet levels at time zero
    initial begin
        wake_events = '0;
        in_deep_sleep = 1'b0;
        power_on_detect_active = 1'b0;
        power_on_event = 1'b0;
        interrupt_event = 1'b0;
    end
    // one-cycle event pulses, then settling time for the sticky flags
    task automatic fire(input wake_events_t ev, input logic irq);
        wake_events <= ev;
        interrupt_event <= irq;
        @(posedge sys_clk);
        wake_events <= '0;
        interrupt_event <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask
    // supply reset pulse, long enough for the three-flop synchroniser
    task automatic por(input logic det);
        power_on_detect_active <= det;
        power_on_event <= 1'b1;
        repeat (8) @(posedge sys_clk);
        power_on_event <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic sleep(input logic s);
        in_deep_sleep <= s;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule

/* sim/tb.sv */
// self-checking bench for sleep_doze_top over apb
// assumes an apb slave that answers within the watchdog span
module tb;
    import sleep_doze_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rstn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, cpu_tick, periph_tick, sleep_s, det, por_s, irq;
    logic [2:0] active_ratio;
    wake_events_t ev;
    int bad_count = 0, cmp_count = 0;
    wake_source src (.sys_clk(sys_clk), .wake_events(ev), .in_deep_sleep(sleep_s),
        .power_on_detect_active(det), .power_on_event(por_s), .interrupt_event(irq));
    sleep_doze_top DUT (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wake_events(ev), .in_deep_sleep(sleep_s),
        .power_on_detect_active(det), .power_on_event(por_s), .interrupt_event(irq),
        .cpu_tick(cpu_tick), .periph_tick(periph_tick), .active_ratio(active_ratio));
    initial forever #4 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer: request held until pready is seen at a rising edge,
    // data taken at that edge; one idle edge follows so strobes never re-rise at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, a > 12'h00c});
    endtask
    task automatic t_por;
        src.por(1'b0);
        rd(12'h000, 32'h0);
        src.por(1'b1);
        rd(12'h000, 32'h1);
        rd(12'h004, 32'h0);
        rd(12'h008, 32'h0);
        rd(12'h00c, 32'h0);
        rd(12'h010, 32'h0);
        $display("por test done");
    endtask
    task automatic t_store;
        wr(12'h004, 32'ha5c3);
        wr(12'h008, 32'h3c5a);
        rd(12'h004, 32'ha5c3);
        rd(12'h008, 32'h3c5a);
        rstn <= 1'b0;
        @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(12'h004, 32'ha5c3);
        wr(12'h000, 32'h0);
        src.sleep(1'b1);
        src.por(1'b1);
        rd(12'h000, 32'h1);
        rd(12'h008, 32'h3c5a);
        src.sleep(1'b0);
        $display("store test done");
    endtask
    task automatic t_wake;
        wr(12'h000, 32'h0);
        src.fire(4'hf, 1'b0);
        rd(12'h000, 32'h0);
        src.sleep(1'b1);
        src.fire(4'h8, 1'b0);
        rd(12'h000, 32'h80);
        src.fire(4'h7, 1'b0);
        rd(12'h000, 32'h9c);
        wr(12'h000, 32'h0);
        rd(12'h000, 32'h0);
        src.sleep(1'b0);
        $display("wake test done");
    endtask
    // clock enable low freezes the divider; ratio 1:2 so a running tick would toggle
    task automatic t_freeze;
        int c;
        logic tick0;
        logic [2:0] ratio0;
        wr(12'h00c, 32'h1800);
        c = 0;
        while (active_ratio !== 3'h1 && c < 300) begin
            @(posedge sys_clk);
            c++;
        end
        ce <= 1'b0;
        repeat (2) @(posedge sys_clk);
        tick0 = cpu_tick;
        ratio0 = active_ratio;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, periph_tick}, 32'h0);
        chk({31'h0, cpu_tick}, {31'h0, tick0});
        chk({29'h0, active_ratio}, 32'h1);
        chk({29'h0, ratio0}, 32'h1);
        ce <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, periph_tick}, 32'h1);
        $display("freeze test done");
    endtask
    task automatic t_doze;
        int c;
        for (int n = 0; n < 8; n++) begin
            wr(12'h00c, 32'h0800 | (n << 12));
            c = 0;
            while (active_ratio !== 3'(n) && c < 300) begin
                @(negedge sys_clk);
                c++;
            end
            chk({29'h0, active_ratio}, 32'(n));
            c = 0;
            do begin
                @(negedge sys_clk);
                c++;
            end while (cpu_tick !== 1'b1 && c < 300);
            c = 0;
            do begin
                @(negedge sys_clk);
                c++;
            end while (cpu_tick !== 1'b1 && c < 300);
            chk(32'(c), 32'h1 << n);
            rd(12'h00c, 32'h0800 | (n << 12));
            @(posedge sys_clk);
        end
        $display("doze test done");
    endtask
    task automatic t_roi;
        wr(12'h00c, 32'h2800);
        src.fire(4'h0, 1'b1);
        rd(12'h00c, 32'h2800);
        wr(12'h00c, 32'ha800);
        src.fire(4'h0, 1'b1);
        rd(12'h00c, 32'ha000);
        chk({29'h0, active_ratio}, 32'h0);
        $display("interrupt test done");
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        t_por();
        t_store();
        t_wake();
        t_doze();
        t_freeze();
        t_roi();
        give_verdict();
    end
endmodule
